// ### rtl/pwt_defs.svh
/*
 * Register map, field positions, reset values and rate constants for the
 * multi-channel PWM timer. Assumes a 32-bit classic Wishbone slave, one
 * register per aligned word, byte address equal to four times the index.
 */
// Overview of operation
// - Three PWM outputs share one period
// - Period register: PWM period and match A event
// - Period m+1, inactive n+1, active m-n
// - External pin rising edge can clock counter
// - Run bit at 1 starts counting
// - Run bit at 0 holds counter and pins
// - Events on any compare match, overflow
// - Pin A port only; B-D selectable
// - Level bit 0: low, high, low again
// - Level bit 1: high, low, high again
// - Pin A level bit ignored
// - Source field: f1..f32, external, oscillator
// - Clear bit: free-run or clear on period
// - Channel registers set B-D change points
// - C buffered holds next period, no pin
// - D buffered holds next B change point
// - Channel equal to period: level unchanged
// - Counter readable and writable any time
// - Cutoff pin: cutoff input or plain input
// - Period/B match loads buffer into register
// - Cutoff low sets all disable bits quickly
`ifndef PWT_DEFS_SVH
`define PWT_DEFS_SVH

// Register indices; byte address is index times four
`define PWT_IDX_MODE 10'h120
`define PWT_IDX_CCR1 10'h121
`define PWT_IDX_CNT 10'h122
`define PWT_IDX_GRA 10'h123
`define PWT_IDX_GRB 10'h124
`define PWT_IDX_GRC 10'h125
`define PWT_IDX_GRD 10'h126
`define PWT_IDX_STAT 10'h127
`define PWT_IDX_OER 10'h128

// Mode register fields
`define PWT_MODE_PWMB 0
`define PWT_MODE_PWMC 1
`define PWT_MODE_PWMD 2
`define PWT_MODE_BFC 4
`define PWT_MODE_BFD 5
`define PWT_MODE_RUN 7

// Control one fields
`define PWT_CCR1_LVLA 0
`define PWT_CCR1_LVLB 1
`define PWT_CCR1_LVLC 2
`define PWT_CCR1_LVLD 3
`define PWT_CCR1_SRC_LO 4
`define PWT_CCR1_SRC_HI 6
`define PWT_CCR1_COUNTER_CLEAR_SELECT 7

// Output enable register fields
`define PWT_OER_PIN_LVL 6
`define PWT_OER_PTO 7

// Reset values
`define PWT_MODE_RST 8'h00
`define PWT_CCR1_RST 8'h00
`define PWT_CNT_RST 16'h0000
`define PWT_GR_RST 16'hFFFF
`define PWT_DIS_RST 4'h0
`define PWT_CNT_MAX 16'hFFFF

// Rates in MHz; the oscillator enable is a fractional divider of clk
`define PWT_CLK_MHZ 100
`define PWT_OSC_MHZ 40

`endif

// ### rtl/pwt_pkg.sv
/*
 * Types shared by the PWM timer modules.
 * Assumes the constants header is included where offsets are needed.
 */
package pwt_pkg;

    // Count source selection, in field order
    typedef enum logic [2:0] {
        PWT_SRC_F1,
        PWT_SRC_F2,
        PWT_SRC_F4,
        PWT_SRC_F8,
        PWT_SRC_F32,
        PWT_SRC_EXT,
        PWT_SRC_OSC,
        PWT_SRC_RSVD
    } pwt_src_e;

    typedef logic [15:0] pwt_word_t;

endpackage : pwt_pkg

// ### rtl/pwt_count_src.sv
/*
 * Count source: turns the selected rate into a one-cycle enable.
 * Assumes clk_i at 100 MHz; the external clock pin is asynchronous and
 * its high and low phases last at least three clk_i cycles.
 */
`timescale 1ns/1ps
`include "pwt_defs.svh"

module pwt_count_src import pwt_pkg::*; (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Selection and pin
    input wire logic [2:0] src_i,
    input wire logic ext_clk_i,
    // Count enable
    output logic tick_o
);

    logic [4:0] div;
    logic [7:0] acc;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    pwt_src_e src;
    logic [7:0] acc_sum;
    logic osc_wrap;
    logic next_tick;

    // Fractional accumulator gives 40 ticks per 100 clocks
    assign src = pwt_src_e'(src_i);
    assign acc_sum = 8'(acc + 8'(`PWT_OSC_MHZ));
    assign osc_wrap = acc_sum >= 8'(`PWT_CLK_MHZ);

    // Source select; the reserved code never ticks
    assign next_tick = (src == PWT_SRC_F1)
        | ((src == PWT_SRC_F2) & div[0])
        | ((src == PWT_SRC_F4) & (&div[1:0]))
        | ((src == PWT_SRC_F8) & (&div[2:0]))
        | ((src == PWT_SRC_F32) & (&div))
        | ((src == PWT_SRC_EXT) & ext_s2 & ~ext_s3)
        | ((src == PWT_SRC_OSC) & osc_wrap);

    // Dividers, pin synchroniser and registered enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div <= 5'h00;
            acc <= 8'h00;
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
            tick_o <= 1'b0;
        end else begin
            div <= 5'(div + 5'h01);
            acc <= osc_wrap ? 8'(acc_sum - 8'(`PWT_CLK_MHZ)) : acc_sum;
            ext_s1 <= ext_clk_i;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            tick_o <= next_tick;
        end
    end

endmodule : pwt_count_src

// ### rtl/pwt_cutoff.sv
/*
 * Forced cutoff input: synchronises the active-low cutoff pin.
 * Assumes the pin is asynchronous and idles high.
 */
`timescale 1ns/1ps

module pwt_cutoff (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pin and enable
    input wire logic cut_n_i,
    input wire logic enable_i,
    // Synchronised level and cutoff request
    output logic pin_lvl_o,
    output logic cut_o
);

    logic cut_s1;
    logic cut_s2;

    // Two flops; reset to the idle level so no false cutoff
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cut_s1 <= 1'b1;
            cut_s2 <= 1'b1;
        end else begin
            cut_s1 <= cut_n_i;
            cut_s2 <= cut_s1;
        end
    end

    // Left combinational to keep the cutoff path short
    assign pin_lvl_o = cut_s2;
    assign cut_o = enable_i & ~cut_s2;

endmodule : pwt_cutoff

// ### rtl/pwt_timer.sv
/*
 * PWM mode of a general-purpose timer with a classic Wishbone slave.
 * One 16-bit up-counter, a period register and three channel registers
 * drive pins B, C and D. Assumes a single 100 MHz clock and a
 * synchronous active-high reset; pins are asynchronous.
 */
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "pwt_defs.svh"

module pwt_timer import pwt_pkg::*; (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pins in
    input wire logic ext_count_clk_i,
    input wire logic cutoff_n_i,
    // Pins out, index 0 is pin A
    output logic [3:0] pin_out_o,
    output logic [3:0] pin_timer_o,
    // Events: overflow, match D, C, B, A
    output logic [4:0] event_o
);

    ////////////////////////////////////////////////////////////////////////
    // Byte-lane merge used by every 16-bit register
    function automatic pwt_word_t wmerge(input pwt_word_t old,
                                         input logic [31:0] dat,
                                         input logic [3:0] sel);
        wmerge = {sel[1] ? dat[15:8] : old[15:8],
                  sel[0] ? dat[7:0] : old[7:0]};
    endfunction : wmerge

    // Next level of one PWM pin
    function automatic logic next_level(input logic cur,
                                        input logic lvl,
                                        input logic en,
                                        input logic adv,
                                        input logic eq,
                                        input logic m_j,
                                        input logic m_a);
        if (!en) begin
            next_level = lvl;
        end else if (!adv || eq) begin
            next_level = cur;
        end else if (m_j) begin
            next_level = ~lvl;
        end else if (m_a) begin
            next_level = lvl;
        end else begin
            next_level = cur;
        end
    endfunction : next_level

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [7:0] mode;
    logic [7:0] ccr1;
    pwt_word_t cnt;
    pwt_word_t gr_a;
    pwt_word_t gr_b;
    pwt_word_t gr_c;
    pwt_word_t gr_d;
    logic [4:0] status;
    logic [3:0] dis;
    logic cutoff_input_enable;

    // Sub-block outputs
    logic tick;
    logic cut;
    logic pin_lvl;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    logic bus_req;
    logic bus_wr;
    logic [9:0] idx;
    logic wr_mode;
    logic wr_ccr1;
    logic wr_cnt;
    logic wr_gra;
    logic wr_grb;
    logic wr_grc;
    logic wr_grd;
    logic wr_stat;
    logic wr_oer;
    logic [31:0] rd_data;

    // Request is taken once; ack blocks a second take
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr = bus_req & wb_we_i;
    assign idx = wb_adr_i[11:2];
    assign wr_mode = bus_wr & (idx == `PWT_IDX_MODE) & wb_sel_i[0];
    assign wr_ccr1 = bus_wr & (idx == `PWT_IDX_CCR1) & wb_sel_i[0];
    assign wr_cnt = bus_wr & (idx == `PWT_IDX_CNT) & (|wb_sel_i[1:0]);
    assign wr_gra = bus_wr & (idx == `PWT_IDX_GRA) & (|wb_sel_i[1:0]);
    assign wr_grb = bus_wr & (idx == `PWT_IDX_GRB) & (|wb_sel_i[1:0]);
    assign wr_grc = bus_wr & (idx == `PWT_IDX_GRC) & (|wb_sel_i[1:0]);
    assign wr_grd = bus_wr & (idx == `PWT_IDX_GRD) & (|wb_sel_i[1:0]);
    assign wr_stat = bus_wr & (idx == `PWT_IDX_STAT) & wb_sel_i[0];
    assign wr_oer = bus_wr & (idx == `PWT_IDX_OER) & wb_sel_i[0];

    // Read mux; unmapped words read as zero
    assign rd_data =
        (idx == `PWT_IDX_MODE) ? {24'h000000, mode} :
        (idx == `PWT_IDX_CCR1) ? {24'h000000, ccr1} :
        (idx == `PWT_IDX_CNT) ? {16'h0000, cnt} :
        (idx == `PWT_IDX_GRA) ? {16'h0000, gr_a} :
        (idx == `PWT_IDX_GRB) ? {16'h0000, gr_b} :
        (idx == `PWT_IDX_GRC) ? {16'h0000, gr_c} :
        (idx == `PWT_IDX_GRD) ? {16'h0000, gr_d} :
        (idx == `PWT_IDX_STAT) ? {27'h0000000, status} :
        (idx == `PWT_IDX_OER) ? {24'h000000, cutoff_input_enable, pin_lvl, 2'h0, dis} :
        32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // Field views
    logic run;
    logic bfc;
    logic bfd;
    logic counter_clear_select;
    logic en_b;
    logic en_c;
    logic en_d;

    assign run = mode[`PWT_MODE_RUN];
    assign bfc = mode[`PWT_MODE_BFC];
    assign bfd = mode[`PWT_MODE_BFD];
    assign counter_clear_select = ccr1[`PWT_CCR1_COUNTER_CLEAR_SELECT];
    // Buffer registers drive no pin of their own
    assign en_b = mode[`PWT_MODE_PWMB];
    assign en_c = mode[`PWT_MODE_PWMC] & ~bfc;
    assign en_d = mode[`PWT_MODE_PWMD] & ~bfd;

    ////////////////////////////////////////////////////////////////////////
    // Count source and cutoff input
    pwt_count_src u_src (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .src_i(ccr1[`PWT_CCR1_SRC_HI:`PWT_CCR1_SRC_LO]),
        .ext_clk_i(ext_count_clk_i),
        .tick_o(tick)
    );

    pwt_cutoff u_cut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cut_n_i(cutoff_n_i),
        .enable_i(cutoff_input_enable),
        .pin_lvl_o(pin_lvl),
        .cut_o(cut)
    );

    ////////////////////////////////////////////////////////////////////////
    // Compare and counter next values
    logic adv;
    logic m_a;
    logic m_b;
    logic m_c;
    logic m_d;
    logic clr_a;
    logic ovf;
    logic [4:0] ev;
    pwt_word_t next_cnt;
    pwt_word_t next_gr_a;
    pwt_word_t next_gr_b;

    // Period register sets the PWM period and also raises the match A event
    assign adv = tick & run;
    assign m_a = cnt == gr_a;
    assign m_b = cnt == gr_b;
    assign m_c = cnt == gr_c;
    assign m_d = cnt == gr_d;
    assign clr_a = adv & counter_clear_select & m_a;
    assign ovf = adv & (cnt == `PWT_CNT_MAX) & ~clr_a;
    assign ev = {ovf, {4{adv}} & {m_d, m_c, m_b, m_a}};

    // Clear on period beats a coinciding software write
    assign next_cnt = clr_a ? `PWT_CNT_RST :
                      wr_cnt ? wmerge(cnt, wb_dat_i, wb_sel_i) :
                      adv ? 16'(cnt + 16'h0001) : cnt;

    // Software write wins over a buffer transfer
    assign next_gr_a = wr_gra ? wmerge(gr_a, wb_dat_i, wb_sel_i) :
                       (adv & m_a & bfc) ? gr_c : gr_a;
    assign next_gr_b = wr_grb ? wmerge(gr_b, wb_dat_i, wb_sel_i) :
                       (adv & m_b & bfd) ? gr_d : gr_b;

    ////////////////////////////////////////////////////////////////////////
    // Pin levels and pin ownership
    logic [3:0] next_pin_out;
    logic [3:0] next_pin_timer;

    // Pin A stays a port and its level bit is ignored
    assign next_pin_out[0] = 1'b0;
    assign next_pin_out[1] = next_level(pin_out_o[1],
        ccr1[`PWT_CCR1_LVLB], en_b, adv, gr_b == gr_a, m_b, m_a);
    assign next_pin_out[2] = next_level(pin_out_o[2],
        ccr1[`PWT_CCR1_LVLC], en_c, adv, gr_c == gr_a, m_c, m_a);
    assign next_pin_out[3] = next_level(pin_out_o[3],
        ccr1[`PWT_CCR1_LVLD], en_d, adv, gr_d == gr_a, m_d, m_a);

    // Cutoff acts directly so pins drop three clocks after the cutoff pin falls
    assign next_pin_timer = {en_d, en_c, en_b, 1'b0}
                          & ~dis & ~{4{cut}};

    ////////////////////////////////////////////////////////////////////////
    // Bus answer: one wait-free cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_data : 32'h00000000;
        end
    end

    // Control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode <= `PWT_MODE_RST;
            ccr1 <= `PWT_CCR1_RST;
            cutoff_input_enable <= 1'b0;
        end else begin
            if (wr_mode) begin
                mode <= wb_dat_i[7:0];
            end
            if (wr_ccr1) begin
                ccr1 <= wb_dat_i[7:0];
            end
            if (wr_oer) begin
                cutoff_input_enable <= wb_dat_i[`PWT_OER_PTO];
            end
        end
    end

    // Counter and compare registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= `PWT_CNT_RST;
            gr_a <= `PWT_GR_RST;
            gr_b <= `PWT_GR_RST;
            gr_c <= `PWT_GR_RST;
            gr_d <= `PWT_GR_RST;
        end else begin
            cnt <= next_cnt;
            gr_a <= next_gr_a;
            gr_b <= next_gr_b;
            gr_c <= wr_grc ? wmerge(gr_c, wb_dat_i, wb_sel_i) : gr_c;
            gr_d <= wr_grd ? wmerge(gr_d, wb_dat_i, wb_sel_i) : gr_d;
        end
    end

    // Sticky status flags: write one clears, a new event wins; dis is written directly and cutoff wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= 5'h00;
            dis <= `PWT_DIS_RST;
            event_o <= 5'h00;
        end else begin
            status <= ev | (status & ~(wr_stat ? wb_dat_i[4:0] : 5'h00));
            dis <= cut ? 4'hF : wr_oer ? wb_dat_i[3:0] : dis;
            event_o <= ev;
        end
    end

    // Pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_out_o <= 4'h0;
            pin_timer_o <= 4'h0;
        end else begin
            pin_out_o <= next_pin_out;
            pin_timer_o <= next_pin_timer;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_req_taken;
        bus_req;
    endsequence

    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    property p_wb_ack;
        s_req_taken |=> s_ack_pulse;
    endproperty
    a_wb_ack: assert property (p_wb_ack)
        else $error("ack not a single cycle after request");

    property p_count_up;
        adv && !clr_a && !wr_cnt |=> cnt == 16'($past(cnt) + 16'h0001);
    endproperty
    a_count_up: assert property (p_count_up)
        else $error("counter did not advance by one");

    // Only pins in PWM use; a disabled pin may settle to its level bit
    property p_hold_stop;
        !run && !wr_cnt && !wr_mode && !wr_ccr1
            |=> cnt == $past(cnt)
                && (pin_out_o & {en_d, en_c, en_b, 1'b0})
                   == ($past(pin_out_o) & {en_d, en_c, en_b, 1'b0});
    endproperty
    a_hold_stop: assert property (p_hold_stop)
        else $error("stopped counter or pin moved");

    property p_clear_period;
        clr_a |=> cnt == 16'h0000;
    endproperty
    a_clear_period: assert property (p_clear_period)
        else $error("counter not cleared on period match");

    property p_b_active;
        adv && en_b && m_b && gr_b != gr_a
            |=> pin_out_o[1] == ~$past(ccr1[`PWT_CCR1_LVLB]);
    endproperty
    a_b_active: assert property (p_b_active)
        else $error("pin B not active after its match");

    property p_b_inactive;
        adv && en_b && m_a && !m_b
            |=> pin_out_o[1] == $past(ccr1[`PWT_CCR1_LVLB]);
    endproperty
    a_b_inactive: assert property (p_b_inactive)
        else $error("pin B not inactive after period match");

    property p_equal_hold;
        adv && en_c && gr_c == gr_a |=> $stable(pin_out_o[2]);
    endproperty
    a_equal_hold: assert property (p_equal_hold)
        else $error("pin C changed with equal compare");

    property p_buf_period;
        adv && m_a && bfc && !wr_gra |=> gr_a == $past(gr_c);
    endproperty
    a_buf_period: assert property (p_buf_period)
        else $error("period buffer not transferred");

    property p_overflow;
        ovf && !wr_cnt |=> event_o[4] && status[4] && cnt == 16'h0000;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow not flagged with wrap");

    property p_cutoff;
        cut |=> dis == 4'hF && pin_timer_o == 4'h0;
    endproperty
    a_cutoff: assert property (p_cutoff)
        else $error("cutoff did not release pins");

    property p_pin_a_port;
        pin_timer_o[0] == 1'b0 && pin_out_o[0] == 1'b0;
    endproperty
    a_pin_a_port: assert property (p_pin_a_port)
        else $error("pin A taken by the timer");

endmodule : pwt_timer

// ### dv/pwt_load.sv
/*
 * Load on the PWM pins: counts high cycles of pins B..D and rising edges
 * of pin B while measure is high; counts clear while it is low.
 * Assumes pins are sampled on the rising edge of the timer clock.
 */
`timescale 1ns/1ps

module pwt_load (
    // Clock
    input wire logic clk_i,
    // Pins and window
    input wire logic [3:0] pin_i,
    input wire logic meas_i,
    // Counts
    output logic [15:0] hi_b_o,
    output logic [15:0] hi_c_o,
    output logic [15:0] hi_d_o,
    output logic [15:0] rise_b_o
);
    logic prev_b;

    // Edge memory runs always, so the first window sample sees a real edge
    always_ff @(posedge clk_i) begin
        prev_b <= pin_i[1];
        if (!meas_i) begin
            hi_b_o <= 16'h0000;
            hi_c_o <= 16'h0000;
            hi_d_o <= 16'h0000;
            rise_b_o <= 16'h0000;
        end else begin
            hi_b_o <= hi_b_o + 16'(pin_i[1]);
            hi_c_o <= hi_c_o + 16'(pin_i[2]);
            hi_d_o <= hi_d_o + 16'(pin_i[3]);
            rise_b_o <= rise_b_o + 16'(pin_i[1] & ~prev_b);
        end
    end
endmodule : pwt_load

// ### dv/pwt_timer_tb.sv
/*
 * Self-checking bench for the PWM timer: Wishbone master tasks, a pin
 * load, one task per scenario. Assumes 100 MHz clock; the bench drives a
 * slow external count clock of 20 timer clocks per period.
 */
`timescale 1ns/1ps
`include "pwt_defs.svh"

module pwt_timer_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] dat = 32'h0;
    logic cut_n = 1'b1;
    logic ext_clk = 1'b0;
    logic meas = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [3:0] pin_out_o;
    logic [3:0] pin_timer_o;
    logic [4:0] event_o;
    logic [15:0] hi_b, hi_c, hi_d, rise_b;
    int fail_count = 0;
    int check_count = 0;

    always #5 clk_i = ~clk_i;

    // External count clock, phases of ten clocks, well above three
    always begin
        repeat (10) @(posedge clk_i);
        ext_clk <= ~ext_clk;
    end

    pwt_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .ext_count_clk_i(ext_clk), .cutoff_n_i(cut_n), .pin_out_o(pin_out_o),
        .pin_timer_o(pin_timer_o), .event_o(event_o));
    pwt_load u_load (.clk_i(clk_i), .pin_i(pin_out_o), .meas_i(meas),
        .hi_b_o(hi_b), .hi_c_o(hi_c), .hi_d_o(hi_d), .rise_b_o(rise_b));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One classic cycle; read data taken at the ack edge only
    task automatic bus(input logic w, input logic [9:0] i,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'h0};
        dat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) chk("ack", 32'h1, 32'h0);
    endtask : bus

    task automatic wr(input logic [9:0] i, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, i, d, q);
    endtask : wr

    task automatic rd(input logic [9:0] i, output logic [31:0] q);
        bus(1'b0, i, 32'h0, q);
    endtask : rd

    // Window of n samples; counts read between edges, before clearing
    task automatic window(input int n);
        @(posedge clk_i);
        meas <= 1'b1;
        repeat (n) @(posedge clk_i);
        meas <= 1'b0;
        @(negedge clk_i);
    endtask : window

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [31:0] q;
        rd(`PWT_IDX_MODE, q);
        chk("mode", 32'h00, q);
        rd(`PWT_IDX_CCR1, q);
        chk("ctrl1", 32'h00, q);
        rd(`PWT_IDX_CNT, q);
        chk("cnt", 32'h0000, q);
        rd(`PWT_IDX_GRA, q);
        chk("gra", 32'hFFFF, q);
        rd(`PWT_IDX_OER, q);
        chk("oer", 32'h40, q);
        wr(10'h200, 32'hFF);
        rd(10'h200, q);
        chk("unmapped", 32'h0, q);
    endtask : t_reset

    // Period 10; B level 0 n=3, C level 1 n=5, D equal to period
    task automatic t_pwm;
        logic [31:0] q;
        wr(`PWT_IDX_CCR1, 32'h85);
        wr(`PWT_IDX_GRA, 32'h9);
        wr(`PWT_IDX_GRB, 32'h3);
        wr(`PWT_IDX_GRC, 32'h5);
        wr(`PWT_IDX_GRD, 32'h9);
        wr(`PWT_IDX_MODE, 32'h87);
        repeat (30) @(posedge clk_i);
        window(40);
        chk("hi_b", 32'd24, 32'(hi_b));
        chk("hi_c", 32'd24, 32'(hi_c));
        chk("hi_d", 32'd0, 32'(hi_d));
        chk("pin_a", 32'h0, 32'(pin_out_o[0]));
        chk("owner", 32'hE, 32'(pin_timer_o));
        rd(`PWT_IDX_STAT, q);
        chk("match_flags", 32'h0F, q);
    endtask : t_pwm

    task automatic t_stop;
        logic [31:0] a, b;
        logic [3:0] p;
        wr(`PWT_IDX_MODE, 32'h07);
        p = pin_out_o;
        rd(`PWT_IDX_CNT, a);
        repeat (25) @(posedge clk_i);
        rd(`PWT_IDX_CNT, b);
        chk("cnt_hold", a, b);
        chk("pin_hold", 32'(p), 32'(pin_out_o));
        wr(`PWT_IDX_CNT, 32'h5);
        rd(`PWT_IDX_CNT, b);
        chk("cnt_wr", 32'h5, b);
    endtask : t_stop

    // Rising edges of B per window for every source; period is 10 ticks
    task automatic t_src;
        int win [7] = '{320, 320, 320, 320, 320, 400, 250};
        int rises [7] = '{32, 16, 8, 4, 1, 2, 10};
        for (int k = 0; k < 7; k++) begin
            wr(`PWT_IDX_MODE, 32'h07);
            wr(`PWT_IDX_CCR1, 32'h84 | (k << 4));
            wr(`PWT_IDX_MODE, 32'h87);
            repeat (40) @(posedge clk_i);
            window(win[k]);
            chk("rises", 32'(rises[k]), 32'(rise_b));
        end
    endtask : t_src

    task automatic t_buf;
        logic [31:0] q;
        wr(`PWT_IDX_MODE, 32'h01);
        wr(`PWT_IDX_CCR1, 32'h80);
        wr(`PWT_IDX_GRC, 32'd19);
        wr(`PWT_IDX_GRD, 32'd7);
        wr(`PWT_IDX_MODE, 32'hB7);
        repeat (30) @(posedge clk_i);
        rd(`PWT_IDX_GRA, q);
        chk("gra_load", 32'd19, q);
        rd(`PWT_IDX_GRB, q);
        chk("grb_load", 32'd7, q);
        chk("c_port", 32'h0, 32'(pin_timer_o[2]));
        chk("d_port", 32'h0, 32'(pin_timer_o[3]));
        chk("b_pwm", 32'h1, 32'(pin_timer_o[1]));
    endtask : t_buf

    task automatic t_ovf;
        logic [31:0] q;
        int n;
        wr(`PWT_IDX_MODE, 32'h00);
        wr(`PWT_IDX_CCR1, 32'h00);
        wr(`PWT_IDX_CNT, 32'hFFFE);
        wr(`PWT_IDX_STAT, 32'h1F);
        wr(`PWT_IDX_MODE, 32'h80);
        n = 0;
        while (event_o[4] !== 1'b1 && n < 10) begin
            @(posedge clk_i);
            n++;
        end
        chk("ovf_evt", 32'h1, 32'(event_o[4]));
        rd(`PWT_IDX_STAT, q);
        chk("ovf_flag", 32'h10, q & 32'h10);
    endtask : t_ovf

    task automatic t_cut;
        logic [31:0] q;
        wr(`PWT_IDX_MODE, 32'h87);
        wr(`PWT_IDX_OER, 32'h80);
        @(posedge clk_i);
        cut_n <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk("cut_pins", 32'h0, 32'(pin_timer_o));
        rd(`PWT_IDX_OER, q);
        chk("cut_dis", 32'hF, q & 32'hF);
        chk("cut_lvl", 32'h0, q & 32'h40);
        cut_n <= 1'b1;
    endtask : t_cut

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    // Main sequence after 16 cycles of reset
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_pwm();
        t_stop();
        t_src();
        t_buf();
        t_ovf();
        t_cut();
        print_verdict();
    end

    // Run needs about 3000 cycles; far longer means a hang
    initial begin
        #200000;
        fail_count++;
        print_verdict();
    end
endmodule : pwt_timer_tb
